//--- rtl/jsr_pkg.sv
// Constants, register map and state encodings for the joystick sensor readout
package jsr_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ADDR_CTRL  = 8'h0f;
	localparam logic [7:0] ADDR_X     = 8'h10;
	localparam logic [7:0] ADDR_Y     = 8'h11;
	localparam logic [7:0] ADDR_XP    = 8'h12;
	localparam logic [7:0] ADDR_XN    = 8'h13;
	localparam logic [7:0] ADDR_YP    = 8'h14;
	localparam logic [7:0] ADDR_YN    = 8'h15;
	localparam logic [7:0] ADDR_SCALE = 8'h2d;

	// ==========================================================
	// Reset values and field positions
	localparam logic [7:0] CTRL_RST    = 8'hf0;
	localparam logic [7:0] THR_RST     = 8'h00;
	localparam logic [7:0] SCALE_RST   = 8'h00;
	localparam logic [7:0] STATUS_BUSY = 8'h00;
	localparam int CTRL_IDLE_BIT    = 7;
	localparam int CTRL_TB_MSB      = 6;
	localparam int CTRL_TB_LSB      = 4;
	localparam int CTRL_WAKE_BIT    = 2;
	localparam int CTRL_SOFTRST_BIT = 1;
	localparam logic [6:0] SLAVE_ADDR_BASE = 7'h40;
	localparam int SCALE_SHIFT = 4;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ     = 20;
	localparam int TCONV_US    = 450;
	localparam int STARTUP_US  = 1000;
	localparam int MS_US       = 1000;
	localparam int TB_BASE_MS  = 20;
	localparam int TB_MAX_SHIFT = 4;
	localparam int TCONV_CYC   = TCONV_US * CLK_MHZ;
	localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
	localparam int MS_CYC      = MS_US * CLK_MHZ;

	// ==========================================================
	// State encodings
	typedef enum logic [2:0] {
		SEQ_STARTUP = 3'h1,
		SEQ_MEASURE = 3'h2,
		SEQ_WAIT    = 3'h4
	} jsr_seq_e;

	typedef enum logic [8:0] {
		BUS_IDLE  = 9'h001,
		BUS_ADDR  = 9'h002,
		BUS_ACKA  = 9'h004,
		BUS_REG   = 9'h008,
		BUS_ACKR  = 9'h010,
		BUS_WDATA = 9'h020,
		BUS_ACKW  = 9'h040,
		BUS_RDATA = 9'h080,
		BUS_RACK  = 9'h100
	} jsr_bus_e;

endpackage : jsr_pkg

//--- rtl/jsr_reg_if.sv
// Register access carrier between the serial slave and the register file
`timescale 1ns/1ns
interface jsr_reg_if;
	logic       wrEn;
	logic       rdEn;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport bus  (output wrEn, output rdEn, output addr, output wdata, input rdata);
	modport regs (input wrEn, input rdEn, input addr, input wdata, output rdata);
endinterface : jsr_reg_if

//--- rtl/jsr_i2c_slave.sv
// Two-wire serial slave giving byte access to the register file
`timescale 1ns/1ns
module jsr_i2c_slave (
	input  wire logic clk,
	input  wire logic rstN,
	input  wire logic scl,
	input  wire logic sdaIn,
	input  wire logic addrPin,
	output logic      sdaOe,
	jsr_reg_if.bus    regBus
);

	// ==========================================================
	// Pin synchronisers
	logic sclS1, sclS2, sclD;
	logic sdaS1, sdaS2, sdaD;

	always_ff @(posedge clk) begin
		if (!rstN) begin
			{sclS1, sclS2, sclD} <= 3'h7;
			{sdaS1, sdaS2, sdaD} <= 3'h7;
		end else begin
			{sclS1, sclS2, sclD} <= {scl, sclS1, sclS2};
			{sdaS1, sdaS2, sdaD} <= {sdaIn, sdaS1, sdaS2};
		end
	end

	logic       sclRise, sclFall, startCond, stopCond;
	logic [6:0] devAddr;
	assign sclRise   = sclS2 & ~sclD;
	assign sclFall   = ~sclS2 & sclD;
	assign startCond = sclS2 & sclD & sdaD & ~sdaS2;
	assign stopCond  = sclS2 & sclD & ~sdaD & sdaS2;
	assign devAddr   = {jsr_pkg::SLAVE_ADDR_BASE[6:1], addrPin};

	// ==========================================================
	// Byte engine
	jsr_pkg::jsr_bus_e state;
	logic [3:0]        bitCnt;
	logic [7:0]        shiftReg, txReg, ptr;
	logic              rwBit, nack;

	assign regBus.addr = ptr;

	// Data moves on falling SCL, sampled on rising SCL
	always_ff @(posedge clk) begin
		if (!rstN) begin
			state        <= jsr_pkg::BUS_IDLE;
			bitCnt       <= 4'h0;
			shiftReg     <= 8'h00;
			txReg        <= 8'h00;
			ptr          <= 8'h00;
			rwBit        <= 1'b0;
			nack         <= 1'b0;
			sdaOe        <= 1'b0;
			regBus.wrEn  <= 1'b0;
			regBus.rdEn  <= 1'b0;
			regBus.wdata <= 8'h00;
		end else begin
			regBus.wrEn <= 1'b0;
			regBus.rdEn <= 1'b0;
			if (startCond) begin
				state  <= jsr_pkg::BUS_ADDR;
				bitCnt <= 4'h0;
				sdaOe  <= 1'b0;
			end else if (stopCond) begin
				state <= jsr_pkg::BUS_IDLE;
				sdaOe <= 1'b0;
			end else if (sclRise) begin
				if (state inside {jsr_pkg::BUS_ADDR, jsr_pkg::BUS_REG, jsr_pkg::BUS_WDATA}) begin
					shiftReg <= {shiftReg[6:0], sdaS2};
					bitCnt   <= bitCnt + 4'h1;
				end else if (state == jsr_pkg::BUS_RACK) begin
					nack <= sdaS2;
					if (!sdaS2) begin
						ptr <= ptr + 8'h01;
					end
				end
			end else if (sclFall) begin
				unique case (state)
					jsr_pkg::BUS_IDLE: begin
					end
					jsr_pkg::BUS_ADDR: if (bitCnt == 4'h8) begin
						if (shiftReg[7:1] == devAddr) begin
							sdaOe <= 1'b1;
							rwBit <= shiftReg[0];
							state <= jsr_pkg::BUS_ACKA;
						end else begin
							state <= jsr_pkg::BUS_IDLE;
						end
					end
					jsr_pkg::BUS_ACKA: begin
						if (rwBit) begin
							txReg       <= regBus.rdata;
							regBus.rdEn <= 1'b1;
							sdaOe       <= ~regBus.rdata[7];
							bitCnt      <= 4'h1;
							state       <= jsr_pkg::BUS_RDATA;
						end else begin
							sdaOe  <= 1'b0;
							bitCnt <= 4'h0;
							state  <= jsr_pkg::BUS_REG;
						end
					end
					jsr_pkg::BUS_REG: if (bitCnt == 4'h8) begin
						ptr   <= shiftReg;
						sdaOe <= 1'b1;
						state <= jsr_pkg::BUS_ACKR;
					end
					jsr_pkg::BUS_ACKR: begin
						sdaOe  <= 1'b0;
						bitCnt <= 4'h0;
						state  <= jsr_pkg::BUS_WDATA;
					end
					jsr_pkg::BUS_WDATA: if (bitCnt == 4'h8) begin
						regBus.wdata <= shiftReg;
						regBus.wrEn  <= 1'b1;
						sdaOe        <= 1'b1;
						state        <= jsr_pkg::BUS_ACKW;
					end
					jsr_pkg::BUS_ACKW: begin
						sdaOe  <= 1'b0;
						bitCnt <= 4'h0;
						ptr    <= ptr + 8'h01;
						state  <= jsr_pkg::BUS_WDATA;
					end
					jsr_pkg::BUS_RDATA: begin
						if (bitCnt == 4'h8) begin
							sdaOe <= 1'b0;
							state <= jsr_pkg::BUS_RACK;
						end else begin
							sdaOe  <= ~txReg[3'(4'h7 - bitCnt)];
							bitCnt <= bitCnt + 4'h1;
						end
					end
					jsr_pkg::BUS_RACK: begin
						if (nack) begin
							state <= jsr_pkg::BUS_IDLE;
						end else begin
							txReg       <= regBus.rdata;
							regBus.rdEn <= 1'b1;
							sdaOe       <= ~regBus.rdata[7];
							bitCnt      <= 4'h1;
							state       <= jsr_pkg::BUS_RDATA;
						end
					end
					default: begin
						sdaOe <= 1'b0;
						state <= jsr_pkg::BUS_IDLE;
					end
				endcase
			end
		end
	end

endmodule : jsr_i2c_slave

//--- rtl/jsr_top.sv
// Joystick sensor start-up, configuration registers and coordinate readout
`timescale 1ns/1ns
module jsr_top #(
	parameter int TCONV_CYC   = jsr_pkg::TCONV_CYC,
	parameter int STARTUP_CYC = jsr_pkg::STARTUP_CYC,
	parameter int MS_CYC      = jsr_pkg::MS_CYC,
	parameter int HALL_W      = 12
) (
	input  wire logic              ref_clk,
	input  wire logic              rst_b,
	input  wire logic              extResetLow,
	input  wire logic              addrSel,
	input  wire logic              scl,
	input  wire logic              sdaIn,
	output logic                   sdaOut,
	output logic                   sdaOe,
	input  wire logic [HALL_W-1:0] hallX,
	input  wire logic [HALL_W-1:0] hallY,
	output logic                   irqOutLow,
	output logic                   irqOutLowOe
);

	// ==========================================================
	// Pin synchronisers and reset merge
	logic extRstS1, extRstS2;
	logic addrS1, addrS2;
	logic softRst;
	logic coreRstN;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			extRstS1 <= 1'b1;
			extRstS2 <= 1'b1;
			addrS1   <= 1'b0;
			addrS2   <= 1'b0;
		end else begin
			extRstS1 <= extResetLow;
			extRstS2 <= extRstS1;
			addrS1   <= addrSel;
			addrS2   <= addrS1;
		end
	end

	// Power-on, external and soft reset all restart the core; nothing
	// watches the supply afterwards, so a dip leaves state undefined
	assign coreRstN = rst_b & extRstS2 & ~softRst;

	// Open drain: the pin is only ever pulled low
	assign sdaOut = 1'b0;

	// ==========================================================
	// Serial slave
	jsr_reg_if regIf ();

	jsr_i2c_slave u_slave (
		.clk     (ref_clk),
		.rstN    (coreRstN),
		.scl     (scl),
		.sdaIn   (sdaIn),
		.addrPin (addrS2),
		.sdaOe   (sdaOe),
		.regBus  (regIf.bus)
	);

	logic yRead;
	assign yRead = regIf.rdEn && (regIf.addr == jsr_pkg::ADDR_Y);

	// ==========================================================
	// Helper functions
	function automatic logic [7:0] satByte(input logic signed [HALL_W+8:0] v);
		if (v > $signed((HALL_W+9)'(127))) begin
			satByte = 8'h7f;
		end else if (v < $signed(-(HALL_W+9)'(128))) begin
			satByte = 8'h80;
		end else begin
			satByte = v[7:0];
		end
	endfunction : satByte

	function automatic logic outsideZone(input logic [7:0] v, input logic [7:0] pos, input logic [7:0] neg);
		outsideZone = ($signed(v) > $signed(pos)) || ($signed(v) < $signed(neg));
	endfunction : outsideZone

	// ==========================================================
	// Configuration registers
	logic [7:0] ctrlBits;
	logic [7:0] xpThr, xnThr, ypThr, ynThr;
	logic [7:0] scaleReg;

	always_ff @(posedge ref_clk) begin
		if (!coreRstN) begin
			ctrlBits <= jsr_pkg::CTRL_RST;
			xpThr    <= jsr_pkg::THR_RST;
			xnThr    <= jsr_pkg::THR_RST;
			ypThr    <= jsr_pkg::THR_RST;
			ynThr    <= jsr_pkg::THR_RST;
			scaleReg <= jsr_pkg::SCALE_RST;
		end else if (regIf.wrEn) begin
			unique case (regIf.addr)
				jsr_pkg::ADDR_CTRL:  ctrlBits <= regIf.wdata;
				jsr_pkg::ADDR_XP:    xpThr    <= regIf.wdata;
				jsr_pkg::ADDR_XN:    xnThr    <= regIf.wdata;
				jsr_pkg::ADDR_YP:    ypThr    <= regIf.wdata;
				jsr_pkg::ADDR_YN:    ynThr    <= regIf.wdata;
				jsr_pkg::ADDR_SCALE: scaleReg <= regIf.wdata;
				default: begin
				end
			endcase
		end
	end

	// Soft reset is a single pulse; the core reset it causes clears the write
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			softRst <= 1'b0;
		end else begin
			softRst <= regIf.wrEn && (regIf.addr == jsr_pkg::ADDR_CTRL)
				&& regIf.wdata[jsr_pkg::CTRL_SOFTRST_BIT];
		end
	end

	// ==========================================================
	// Measurement pacing
	logic       msTick;
	int         msCnt;
	logic [2:0] tbCode;
	int         periodMs;

	always_ff @(posedge ref_clk) begin
		if (!coreRstN) begin
			msCnt  <= 0;
			msTick <= 1'b0;
		end else if (msCnt == MS_CYC - 1) begin
			msCnt  <= 0;
			msTick <= 1'b1;
		end else begin
			msCnt  <= msCnt + 1;
			msTick <= 1'b0;
		end
	end

	// Longer timebases save power at the cost of reaction time
	assign tbCode = ctrlBits[jsr_pkg::CTRL_TB_MSB:jsr_pkg::CTRL_TB_LSB];
	always_comb begin
		if (int'(tbCode) > jsr_pkg::TB_MAX_SHIFT) begin
			periodMs = jsr_pkg::TB_BASE_MS << jsr_pkg::TB_MAX_SHIFT;
		end else begin
			periodMs = jsr_pkg::TB_BASE_MS << tbCode;
		end
	end

	// ==========================================================
	// Start-up / measure / wait sequencer
	jsr_pkg::jsr_seq_e seqState;
	int                phaseCnt;
	int                waitMs;
	logic              resetDone;
	logic              measDone;
	logic              measPending;

	always_ff @(posedge ref_clk) begin
		if (!coreRstN) begin
			seqState    <= jsr_pkg::SEQ_STARTUP;
			phaseCnt    <= 0;
			waitMs      <= 0;
			resetDone   <= 1'b0;
			measDone    <= 1'b0;
			measPending <= 1'b0;
		end else begin
			measDone <= 1'b0;
			unique case (seqState)
				jsr_pkg::SEQ_STARTUP: begin
					if (phaseCnt == STARTUP_CYC - 1) begin
						resetDone <= 1'b1;
						phaseCnt  <= 0;
						seqState  <= jsr_pkg::SEQ_MEASURE;
					end else begin
						phaseCnt <= phaseCnt + 1;
					end
				end
				jsr_pkg::SEQ_MEASURE: begin
					if (phaseCnt == TCONV_CYC - 1) begin
						measDone <= 1'b1;
						phaseCnt <= 0;
						waitMs   <= 0;
						seqState <= jsr_pkg::SEQ_WAIT;
					end else begin
						phaseCnt <= phaseCnt + 1;
					end
				end
				jsr_pkg::SEQ_WAIT: begin
					if (ctrlBits[jsr_pkg::CTRL_IDLE_BIT]) begin
						// Idle mode measures only after the pair was consumed
						if (measPending) begin
							measPending <= 1'b0;
							seqState    <= jsr_pkg::SEQ_MEASURE;
						end
					end else if (msTick) begin
						if (waitMs + 1 >= periodMs) begin
							waitMs      <= 0;
							measPending <= 1'b0;
							seqState    <= jsr_pkg::SEQ_MEASURE;
						end else begin
							waitMs <= waitMs + 1;
						end
					end
				end
				default: begin
					phaseCnt <= 0;
					seqState <= jsr_pkg::SEQ_STARTUP;
				end
			endcase
			// Last so a read landing as a measurement starts is kept
			if (yRead) begin
				measPending <= 1'b1;
			end
		end
	end

	// ==========================================================
	// Coordinate conversion and storage
	logic signed [HALL_W+8:0] prodX, prodY;
	logic [7:0]               xCoord, yCoord;

	always_comb begin
		prodX = ($signed(hallX) * $signed({1'b0, scaleReg})) >>> jsr_pkg::SCALE_SHIFT;
		prodY = ($signed(hallY) * $signed({1'b0, scaleReg})) >>> jsr_pkg::SCALE_SHIFT;
	end

	always_ff @(posedge ref_clk) begin
		if (!coreRstN) begin
			xCoord <= 8'h00;
			yCoord <= 8'h00;
		end else if (measDone) begin
			xCoord <= satByte(prodX);
			yCoord <= satByte(prodY);
		end
	end

	// ==========================================================
	// Data-ready flag and interrupt pin
	logic readyFlag;
	logic outside;
	assign outside = outsideZone(satByte(prodX), xpThr, xnThr) || outsideZone(satByte(prodY), ypThr, ynThr);

	// A new pair in the same cycle as the Y read wins over the clear
	always_ff @(posedge ref_clk) begin
		if (!coreRstN) begin
			readyFlag   <= 1'b0;
			irqOutLow   <= 1'b1;
			irqOutLowOe <= 1'b0;
		end else if (measDone) begin
			readyFlag <= 1'b1;
			if (ctrlBits[jsr_pkg::CTRL_WAKE_BIT]) begin
				irqOutLow   <= ~outside;
				irqOutLowOe <= outside;
			end else begin
				irqOutLow   <= 1'b0;
				irqOutLowOe <= 1'b1;
			end
		end else if (yRead) begin
			readyFlag   <= 1'b0;
			irqOutLow   <= 1'b1;
			irqOutLowOe <= 1'b0;
		end
	end

	// ==========================================================
	// Read mux; unmapped offsets read as zero
	always_comb begin
		unique case (regIf.addr)
			jsr_pkg::ADDR_CTRL: begin
				if (resetDone) begin
					regIf.rdata = {ctrlBits[7:2], 1'b0, readyFlag};
				end else begin
					regIf.rdata = jsr_pkg::STATUS_BUSY;
				end
			end
			jsr_pkg::ADDR_X:     regIf.rdata = xCoord;
			jsr_pkg::ADDR_Y:     regIf.rdata = yCoord;
			jsr_pkg::ADDR_XP:    regIf.rdata = xpThr;
			jsr_pkg::ADDR_XN:    regIf.rdata = xnThr;
			jsr_pkg::ADDR_YP:    regIf.rdata = ypThr;
			jsr_pkg::ADDR_YN:    regIf.rdata = ynThr;
			jsr_pkg::ADDR_SCALE: regIf.rdata = scaleReg;
			default:             regIf.rdata = 8'h00;
		endcase
	end

endmodule : jsr_top

//--- sim/jsr_monitor.sv
// Concurrent checks on the joystick readout top-level ports
`timescale 1ns/1ns
module jsr_monitor (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic extResetLow,
	input wire logic scl,
	input wire logic sdaOe,
	input wire logic irqOutLow,
	input wire logic irqOutLowOe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	// ==========================================================
	// Sequences
	sequence s_extPulse;
		!extResetLow [*3];
	endsequence
	sequence s_sclIdle;
		scl [*8];
	endsequence
	sequence s_quiet;
		irqOutLow && !sdaOe && !irqOutLowOe;
	endsequence

	// ==========================================================
	// Properties
	property p_rstQuiet;
		disable iff (1'b0) !rst_b |=> s_quiet;
	endproperty
	property p_extRst;
		s_extPulse |-> ##[1:3] s_quiet;
	endproperty
	property p_startup;
		$rose(rst_b) |-> irqOutLow [*8];
	endproperty
	property p_oeInv;
		irqOutLowOe == !irqOutLow;
	endproperty
	// A Y read needs a clock fall first, so a quiet clock keeps the irq low
	property p_irqHold;
		$fell(irqOutLow) && $past(scl, 2) && $past(scl, 3) && $past(extResetLow) && $past(extResetLow, 2)
			|=> !irqOutLow [*2];
	endproperty
	property p_sclIdle;
		s_sclIdle |-> !sdaOe;
	endproperty
	// A driven bit lasts at least seven ref_clk cycles
	property p_bitLen;
		$rose(sdaOe) |=> sdaOe [*6];
	endproperty
	property p_sdaSteady;
		scl [*4] |-> $stable(sdaOe);
	endproperty

	a_rstQuiet: assert property (p_rstQuiet) else $error("outputs not quiet in reset");
	a_extRst: assert property (p_extRst) else $error("external reset ignored");
	a_startup: assert property (p_startup) else $error("irq during start-up");
	a_oeInv: assert property (p_oeInv) else $error("irq enable mismatch");
	a_irqHold: assert property (p_irqHold) else $error("irq pulse too short");
	a_sclIdle: assert property (p_sclIdle) else $error("data driven on idle bus");
	a_bitLen: assert property (p_bitLen) else $error("data bit too short");
	a_sdaSteady: assert property (p_sdaSteady) else $error("data moved with clock high");
endmodule : jsr_monitor

//--- sim/jsr_host.sv
// Behavioural serial bus master standing in for the host controller
`timescale 1ns/1ns
module jsr_host (
	input  wire logic ref_clk,
	input  wire logic sdaWire,
	output logic      scl,
	output logic      sdaLow
);
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end

	// ==========================================================
	// Bit level, 400 ns serial period
	task automatic q;
		repeat (2) @(posedge ref_clk);
	endtask : q
	task automatic bitIo(input logic b, output logic seen);
		q();
		sdaLow <= !b;
		q();
		scl <= 1'b1;
		q();
		seen = sdaWire;
		q();
		scl <= 1'b0;
	endtask : bitIo
	task automatic start;
		q();
		sdaLow <= 1'b0;
		q();
		scl <= 1'b1;
		q();
		sdaLow <= 1'b1;
		q();
		scl <= 1'b0;
	endtask : start
	task automatic stop;
		q();
		sdaLow <= 1'b1;
		q();
		scl <= 1'b1;
		q();
		sdaLow <= 1'b0;
		q();
	endtask : stop

	// ==========================================================
	// Byte level, one register byte per access
	task automatic byteOut(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitIo(b[i], s);
		bitIo(1'b1, s);
		ack = !s;
	endtask : byteOut
	task automatic wr8(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d, output logic ack);
		logic t;
		start();
		byteOut({dev, 1'b0}, ack);
		if (ack) begin
			byteOut(a, t);
			byteOut(d, t);
		end
		stop();
	endtask : wr8
	task automatic rd8(input logic [6:0] dev, input logic [7:0] a, output logic [7:0] d, output logic ack);
		logic t;
		d = 8'h00;
		start();
		byteOut({dev, 1'b0}, ack);
		if (ack) begin
			byteOut(a, t);
			start();
			byteOut({dev, 1'b1}, t);
			for (int i = 7; i >= 0; i--)
				bitIo(1'b1, d[i]);
			bitIo(1'b1, t);
		end
		stop();
	endtask : rd8
endmodule : jsr_host

//--- sim/test_jsr_top.sv
// Self-checking bench for the joystick readout block
`timescale 1ns/1ns
module test_jsr_top;
	localparam int MSC  = 10;
	localparam int TCV  = 20;
	// Timebase 3 waits 160 ms after each conversion ends
	localparam int PACE = jsr_pkg::TB_BASE_MS * 8 * MSC + TCV;
	logic        ref_clk, rst_b, extResetLow, addrSel, sdaOut, sdaOe, irqOutLow, irqOutLowOe;
	logic        scl, sdaLow, sdaWire, ack;
	logic [11:0] hallX, hallY;
	logic [7:0]  rd;
	int          n_fail, comparisons, offX, offY;
	time         t1;

	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	assign sdaWire = !(sdaLow || sdaOe);

	jsr_top #(.TCONV_CYC(TCV), .STARTUP_CYC(30), .MS_CYC(MSC), .HALL_W(12)) DUT (
		.ref_clk(ref_clk), .rst_b(rst_b), .extResetLow(extResetLow), .addrSel(addrSel), .scl(scl),
		.sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .hallX(hallX), .hallY(hallY),
		.irqOutLow(irqOutLow), .irqOutLowOe(irqOutLowOe));
	jsr_host host (.ref_clk(ref_clk), .sdaWire(sdaWire), .scl(scl), .sdaLow(sdaLow));

	// ==========================================================
	// Shared helpers
	task automatic final_report;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : final_report
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
		host.rd8(7'h40, a, rd, ack);
		check(rd, exp);
	endtask : rdChk
	task automatic waitIrq(input int bound);
		for (int i = 0; i < bound && irqOutLow !== 1'b0; i++)
			@(posedge ref_clk);
		if (irqOutLow !== 1'b0) begin
			check(irqOutLow, 1'b0);
			final_report();
		end
	endtask : waitIrq
	// Scaled, saturated coordinate for the 0Dh scale setting
	function automatic logic [7:0] coord(input int h);
		int v;
		v = (h * 13) >>> jsr_pkg::SCALE_SHIFT;
		return (v > 127) ? 8'h7f : (v < -128) ? 8'h80 : v[7:0];
	endfunction : coord

	// ==========================================================
	// Scenarios
	task automatic t_startup;
		rd = 8'h00;
		for (int i = 0; i < 20 && rd !== 8'hf0 && rd !== 8'hf1; i++)
			host.rd8(7'h40, jsr_pkg::ADDR_CTRL, rd, ack);
		check(rd & 8'hfe, jsr_pkg::CTRL_RST);
		check(sdaOut, 1'b0);
		for (int a = 8'h12; a <= 8'h15; a++)
			rdChk(8'(a), jsr_pkg::THR_RST);
		rdChk(jsr_pkg::ADDR_SCALE, jsr_pkg::SCALE_RST);
		rdChk(8'h20, 8'h00);
		host.wr8(7'h40, jsr_pkg::ADDR_X, 8'h55, ack);
		rdChk(jsr_pkg::ADDR_X, 8'h00);
	endtask : t_startup
	task automatic t_addr;
		host.rd8(7'h41, jsr_pkg::ADDR_CTRL, rd, ack);
		check(ack, 1'b0);
		addrSel <= 1'b1;
		repeat (4) @(posedge ref_clk);
		host.rd8(7'h41, jsr_pkg::ADDR_SCALE, rd, ack);
		check(ack, 1'b1);
		check(rd, jsr_pkg::SCALE_RST);
		addrSel <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask : t_addr
	task automatic t_cal;
		logic [7:0] thr [4];
		int sx, sy;
		host.wr8(7'h40, jsr_pkg::ADDR_SCALE, 8'h0d, ack);
		rdChk(jsr_pkg::ADDR_SCALE, 8'h0d);
		host.wr8(7'h40, jsr_pkg::ADDR_CTRL, 8'h00, ack);
		host.rd8(7'h40, jsr_pkg::ADDR_Y, rd, ack);
		sx = 0;
		sy = 0;
		for (int i = 0; i < 16; i++) begin
			waitIrq(1000);
			rdChk(jsr_pkg::ADDR_X, coord(32));
			sx += int'(signed'(rd));
			rdChk(jsr_pkg::ADDR_Y, coord(-48));
			sy += int'(signed'(rd));
		end
		offX = -(sx >>> 4);
		offY = -(sy >>> 4);
		thr = '{8'(10 - offX), 8'(-10 - offX), 8'(10 - offY), 8'(-10 - offY)};
		for (int a = 0; a < 4; a++)
			host.wr8(7'h40, 8'(8'h12 + a), thr[a], ack);
		for (int a = 0; a < 4; a++)
			rdChk(8'(8'h12 + a), thr[a]);
	endtask : t_cal
	task automatic t_wake;
		host.wr8(7'h40, jsr_pkg::ADDR_CTRL, 8'h04, ack);
		host.rd8(7'h40, jsr_pkg::ADDR_Y, rd, ack);
		repeat (400) @(posedge ref_clk);
		check(irqOutLow, 1'b1);
		hallX <= 12'h7ff;
		waitIrq(600);
		rdChk(jsr_pkg::ADDR_X, coord(2047));
		hallX <= 12'h020;
	endtask : t_wake
	task automatic t_pace;
		host.wr8(7'h40, jsr_pkg::ADDR_CTRL, 8'h30, ack);
		waitIrq(2000);
		host.rd8(7'h40, jsr_pkg::ADDR_Y, rd, ack);
		check(irqOutLow, 1'b1);
		waitIrq(2000);
		t1 = $time;
		host.rd8(7'h40, jsr_pkg::ADDR_Y, rd, ack);
		waitIrq(2000);
		check(($time - t1) >= 50 * (PACE - MSC), 1'b1);
		check(($time - t1) <= 50 * PACE, 1'b1);
	endtask : t_pace
	// Idle mode: no new pair until Y has been read
	task automatic t_idle;
		host.wr8(7'h40, jsr_pkg::ADDR_CTRL, 8'h80, ack);
		host.rd8(7'h40, jsr_pkg::ADDR_Y, rd, ack);
		waitIrq(200);
		hallX <= 12'hfc0;
		repeat (2000) @(posedge ref_clk);
		rdChk(jsr_pkg::ADDR_X, coord(32));
		rdChk(jsr_pkg::ADDR_CTRL, 8'h81);
		host.rd8(7'h40, jsr_pkg::ADDR_Y, rd, ack);
		waitIrq(200);
		rdChk(jsr_pkg::ADDR_X, coord(-64));
	endtask : t_idle

	initial begin
		n_fail = 0;
		comparisons = 0;
		rst_b = 1'b0;
		extResetLow = 1'b1;
		addrSel = 1'b0;
		hallX = 12'h020;
		hallY = 12'hfd0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		t_startup();
		t_addr();
		t_cal();
		t_wake();
		t_pace();
		t_idle();
		extResetLow <= 1'b0;
		repeat (4) @(posedge ref_clk);
		extResetLow <= 1'b1;
		t_startup();
		final_report();
	end
endmodule : test_jsr_top

bind jsr_top jsr_monitor u_mon (.ref_clk(ref_clk), .rst_b(rst_b), .extResetLow(extResetLow), .scl(scl),
	.sdaOe(sdaOe), .irqOutLow(irqOutLow), .irqOutLowOe(irqOutLowOe));
